/* rtl/retimer_pkg.sv */
// constants, field layout and state encodings for the retimer power and output control
// assumes the control logic runs on one 200 MHz clock; pins reach it unsynchronised

package retimer_pkg;

    localparam logic [7:0] REG_POWER_DOWN = 8'h09;
    localparam logic [7:0] REG_SLEW_TERM  = 8'h0B;
    localparam logic [7:0] REG_SWING_EMPH = 8'h0C;
    localparam logic [7:0] REG_RESET      = 8'h00;

    localparam int PD_BIT      = 3;
    localparam int RATIO_BIT   = 1;
    localparam int STATE_LSB   = 4;
    localparam int SLEW_LSB    = 6;
    localparam int TERM_LSB    = 3;
    localparam int SWING_LSB   = 2;
    localparam int DSWING_LSB  = 5;
    localparam int CSWING_LSB  = 2;
    localparam int EMPH_LSB    = 0;

    localparam logic [1:0] TERM_NONE    = 2'h0;
    localparam logic [1:0] TERM_150_300 = 2'h1;
    localparam logic [1:0] TERM_75_150  = 2'h3;
    localparam logic [1:0] EMPH_0DB     = 2'h0;
    localparam logic [1:0] EMPH_M2DB    = 2'h1;
    localparam logic [5:0] SWING_MINUS7 = 6'h3F;
    localparam logic [5:0] SWING_RESET  = 6'h00;

    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam int         STRAP_TERM   = 0;
    localparam int         STRAP_EMPH   = 1;
    localparam int         STRAP_SLEW   = 2;
    localparam int         STRAP_COUNT  = 3;

    typedef enum logic [1:0] {
        PWR_OFF       = 2'h0,
        PWR_STANDBY   = 2'h1,
        PWR_NORMAL    = 2'h3,
        PWR_SOFT_DOWN = 2'h2
    } power_state_t;

    typedef enum logic [1:0] {
        LVL_LOW  = 2'h0,
        LVL_MID  = 2'h1,
        LVL_HIGH = 2'h3
    } strap_level_t;

    typedef enum logic [2:0] {
        I2C_IDLE  = 3'h0,
        I2C_ADDR  = 3'h1,
        I2C_PTR   = 3'h3,
        I2C_WDATA = 3'h2,
        I2C_RDATA = 3'h6
    } i2c_state_t;

endpackage : retimer_pkg

/* rtl/retimer_power_control.sv */
// power state decision, hotplug mirror, strap decode and i2c register file
// assumes all pin inputs are asynchronous; the i2c pins are open drain and resolved outside
`timescale 1ns/10ps
`default_nettype none

module retimer_power_control #(
    parameter logic [6:0] DEV_ADDR = 7'h2C
) (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire logic                      power_enable,
    input  wire logic                      sink_hotplug_in,
    input  wire logic                      signal_detect,
    input  wire logic [2:0]                strap_above,
    input  wire logic [2:0]                strap_below,
    input  wire logic                      local_i2c_clock,
    input  wire logic                      local_i2c_data_in,
    output logic                           local_i2c_data_out,
    output logic                           local_i2c_data_oe,
    output logic                           source_hotplug_out,
    output retimer_pkg::power_state_t      power_state,
    output logic                           i2c_port_active,
    output logic                           main_link_rx_enable,
    output logic                           main_link_data_outputs,
    output logic                           cdr_enable,
    output logic                           ddc_enable,
    output logic                           source_aux_channel,
    output logic [1:0]                     output_termination_select,
    output logic [1:0]                     edge_rate_select,
    output logic [1:0]                     emphasis_field,
    output logic                           emphasis_minus2db,
    output logic [2:0]                     data_lane_swing,
    output logic [2:0]                     clock_lane_swing,
    output logic                           swing_reduce_7pct,
    output logic                           high_rate_ratio_flag
);
    import retimer_pkg::*;

    localparam int NSYNC = 11;
    // scl and sda flops reset to the idle bus level, else reset release fakes an edge
    localparam logic [NSYNC-1:0] SYNC_IDLE = 11'h018;

    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic             pe_s;
    logic             hpd_s;
    logic             sd_s;
    logic             scl_s;
    logic             sda_s;
    logic [2:0]       above_s;
    logic [2:0]       below_s;
    logic             pe_prev_q;
    logic             scl_prev_q;
    logic             sda_prev_q;
    logic             pe_rise;
    strap_level_t     strap_lvl [STRAP_COUNT];

    power_state_t     pwr_q;
    power_state_t     pwr_d;
    logic             pd_entry;
    logic             hpd_out_q;

    logic             pd_bit_q;
    logic             ratio_q;
    logic [1:0]       slew_q;
    logic [1:0]       term_q;
    logic [5:0]       swing_q;
    logic [1:0]       emph_q;
    logic             auto_term_q;

    i2c_state_t       i2c_q;
    logic [3:0]       bit_cnt_q;
    logic [7:0]       shift_q;
    logic [7:0]       tx_q;
    logic [7:0]       ptr_q;
    logic             ack_q;
    logic             drive_q;
    logic [7:0]       rd_data;
    logic             start_cond;
    logic             stop_cond;
    logic             scl_rise;
    logic             scl_fall;
    logic             wr_stb;

    // every pin passes two flops before use
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end
        else
        begin
            sync1_q <= {strap_below, strap_above, local_i2c_data_in, local_i2c_clock,
                        signal_detect, sink_hotplug_in, power_enable};
            sync2_q <= sync1_q;
        end
    end

    assign pe_s    = sync2_q[0];
    assign hpd_s   = sync2_q[1];
    assign sd_s    = sync2_q[2];
    assign scl_s   = sync2_q[3];
    assign sda_s   = sync2_q[4];
    assign above_s = sync2_q[7:5];
    assign below_s = sync2_q[10:8];

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pe_prev_q  <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            pe_prev_q  <= pe_s;
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign pe_rise = pe_s && !pe_prev_q;

    // a floating strap trips neither comparator, which reads as mid
    genvar gi;
    generate
        for (gi = 0; gi < STRAP_COUNT; gi++)
        begin : g_strap
            assign strap_lvl[gi] = above_s[gi] ? LVL_HIGH :
                                   below_s[gi] ? LVL_LOW : LVL_MID;
        end
    endgenerate

    // decided afresh every cycle, so no command is needed to leave standby
    always_comb
    begin
        if (!pe_s)
            pwr_d = PWR_OFF;
        else if (!hpd_s)
            pwr_d = PWR_STANDBY;
        else if (pd_bit_q)
            pwr_d = PWR_SOFT_DOWN;
        else
            pwr_d = PWR_NORMAL;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pwr_q <= PWR_OFF;
        else
            pwr_q <= pwr_d;
    end

    assign pd_entry = (pwr_q == PWR_NORMAL) && (pwr_d != PWR_NORMAL);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            hpd_out_q <= 1'b0;
        else
            hpd_out_q <= hpd_s;
    end

    assign source_hotplug_out     = hpd_out_q;
    assign power_state            = pwr_q;
    assign i2c_port_active        = (pwr_q != PWR_OFF);
    assign main_link_rx_enable    = (pwr_q == PWR_NORMAL);
    assign main_link_data_outputs = (pwr_q == PWR_NORMAL) && sd_s;
    assign cdr_enable             = (pwr_q == PWR_NORMAL) && sd_s;
    assign ddc_enable             = (pwr_q == PWR_NORMAL);
    assign source_aux_channel     = (pwr_q == PWR_NORMAL);

    // configuration: held clear while enable is low, strap defaults loaded on its rise
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pd_bit_q    <= 1'b0;
            slew_q      <= TERM_NONE;
            term_q      <= TERM_NONE;
            swing_q     <= SWING_RESET;
            emph_q      <= EMPH_0DB;
            auto_term_q <= 1'b0;
        end
        else if (!pe_s)
        begin
            pd_bit_q    <= 1'b0;
            slew_q      <= TERM_NONE;
            term_q      <= TERM_NONE;
            swing_q     <= SWING_RESET;
            emph_q      <= EMPH_0DB;
            auto_term_q <= 1'b0;
        end
        else if (pe_rise)
        begin
            pd_bit_q    <= 1'b0;
            slew_q      <= strap_lvl[STRAP_SLEW];
            term_q      <= (strap_lvl[STRAP_TERM] == LVL_HIGH) ? TERM_75_150 : TERM_NONE;
            auto_term_q <= (strap_lvl[STRAP_TERM] == LVL_MID);
            emph_q      <= (strap_lvl[STRAP_EMPH] == LVL_LOW) ? EMPH_M2DB : EMPH_0DB;
            swing_q     <= SWING_RESET;
        end
        else if (wr_stb)
        begin
            unique case (ptr_q)
                REG_POWER_DOWN: pd_bit_q <= shift_q[PD_BIT];
                REG_SLEW_TERM:
                begin
                    slew_q      <= shift_q[SLEW_LSB +: 2];
                    term_q      <= shift_q[TERM_LSB +: 2];
                    auto_term_q <= 1'b0;
                end
                REG_SWING_EMPH:
                begin
                    swing_q <= shift_q[SWING_LSB +: 6];
                    emph_q  <= shift_q[EMPH_LSB +: 2];
                end
                default: ;
            endcase
        end
    end

    // power-down entry beats a coincident write; the source must set it again afterwards
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ratio_q <= 1'b0;
        else if (!pe_s || pd_entry)
            ratio_q <= 1'b0;
        else if (wr_stb && ptr_q == REG_POWER_DOWN)
            ratio_q <= shift_q[RATIO_BIT];
    end

    // auto termination follows the ratio flag until software writes the field
    always_comb
    begin
        if (auto_term_q)
            output_termination_select = ratio_q ? TERM_75_150 : TERM_150_300;
        else
            output_termination_select = term_q;
    end

    assign edge_rate_select     = slew_q;
    assign emphasis_field       = emph_q;
    assign emphasis_minus2db    = (emph_q == EMPH_M2DB);
    assign data_lane_swing      = swing_q[DSWING_LSB - SWING_LSB +: 3];
    assign clock_lane_swing     = swing_q[CSWING_LSB - SWING_LSB +: 3];
    assign swing_reduce_7pct    = (swing_q == SWING_MINUS7);
    assign high_rate_ratio_flag = ratio_q;

    always_comb
    begin
        rd_data = REG_RESET;
        unique case (ptr_q)
            REG_POWER_DOWN:
            begin
                rd_data[PD_BIT]           = pd_bit_q;
                rd_data[RATIO_BIT]        = ratio_q;
                rd_data[STATE_LSB +: 2]   = pwr_q;
            end
            REG_SLEW_TERM:
            begin
                rd_data[SLEW_LSB +: 2]    = slew_q;
                rd_data[TERM_LSB +: 2]    = term_q;
            end
            REG_SWING_EMPH:
            begin
                rd_data[SWING_LSB +: 6]   = swing_q;
                rd_data[EMPH_LSB +: 2]    = emph_q;
            end
            default: ;
        endcase
    end

    // i2c target on the oversampled pins; enable low holds it idle and off the bus
    assign start_cond = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_cond  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    assign scl_rise   = scl_s && !scl_prev_q;
    assign scl_fall   = !scl_s && scl_prev_q;
    assign wr_stb     = scl_fall && !ack_q && (bit_cnt_q == BYTE_BITS) && (i2c_q == I2C_WDATA);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            i2c_q     <= I2C_IDLE;
            bit_cnt_q <= '0;
            shift_q   <= REG_RESET;
            tx_q      <= REG_RESET;
            ptr_q     <= REG_RESET;
            ack_q     <= 1'b0;
            drive_q   <= 1'b0;
        end
        else if (!pe_s)
        begin
            i2c_q   <= I2C_IDLE;
            ptr_q   <= REG_RESET;
            ack_q   <= 1'b0;
            drive_q <= 1'b0;
        end
        else if (stop_cond)
        begin
            i2c_q   <= I2C_IDLE;
            ack_q   <= 1'b0;
            drive_q <= 1'b0;
        end
        else if (start_cond)
        begin
            i2c_q     <= I2C_ADDR;
            bit_cnt_q <= '0;
            ack_q     <= 1'b0;
            drive_q   <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (ack_q)
            begin
                if (i2c_q == I2C_RDATA && sda_s)
                    i2c_q <= I2C_IDLE;
            end
            else if (i2c_q != I2C_IDLE)
            begin
                shift_q   <= {shift_q[6:0], sda_s};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
        else if (scl_fall)
        begin
            if (ack_q)
            begin
                ack_q     <= 1'b0;
                bit_cnt_q <= '0;
                if (i2c_q == I2C_RDATA)
                begin
                    drive_q <= ~rd_data[7];
                    tx_q    <= {rd_data[6:0], 1'b1};
                end
                else
                    drive_q <= 1'b0;
            end
            else if (bit_cnt_q == BYTE_BITS)
            begin
                ack_q <= 1'b1;
                unique case (i2c_q)
                    I2C_ADDR:
                    begin
                        if (shift_q[7:1] == DEV_ADDR)
                        begin
                            drive_q <= 1'b1;
                            i2c_q   <= shift_q[0] ? I2C_RDATA : I2C_PTR;
                        end
                        else
                        begin
                            ack_q <= 1'b0;
                            i2c_q <= I2C_IDLE;
                        end
                    end
                    I2C_PTR:
                    begin
                        drive_q <= 1'b1;
                        ptr_q   <= shift_q;
                        i2c_q   <= I2C_WDATA;
                    end
                    I2C_WDATA:
                    begin
                        drive_q <= 1'b1;
                        ptr_q   <= ptr_q + 8'h01;
                    end
                    I2C_RDATA:
                    begin
                        drive_q <= 1'b0;
                        ptr_q   <= ptr_q + 8'h01;
                    end
                    I2C_IDLE: ack_q <= 1'b0;
                endcase
            end
            else if (i2c_q == I2C_RDATA)
            begin
                drive_q <= ~tx_q[7];
                tx_q    <= {tx_q[6:0], 1'b1};
            end
        end
    end

    assign local_i2c_data_out = 1'b0;
    assign local_i2c_data_oe  = drive_q;

    a_off_when_disabled: assert property (@(posedge clk) disable iff (reset)
        !pe_s |=> (pwr_q == PWR_OFF) && !i2c_port_active && !local_i2c_data_oe)
        else $error("enable low did not shut the device down");

    a_regs_cleared: assert property (@(posedge clk) disable iff (reset)
        !pe_s ##1 pe_s |=> !pd_bit_q && !ratio_q && (swing_q == SWING_RESET))
        else $error("settings not back to default after enable cycle");

    a_standby_mode: assert property (@(posedge clk) disable iff (reset)
        pe_s && !hpd_s |=> (pwr_q == PWR_STANDBY) && i2c_port_active && !ddc_enable)
        else $error("hotplug low did not give power-down with i2c active");

    a_soft_down: assert property (@(posedge clk) disable iff (reset)
        pe_s && hpd_s && pd_bit_q |=> pwr_q == PWR_SOFT_DOWN)
        else $error("software power-down bit ignored");

    a_soft_down_hiz: assert property (@(posedge clk) disable iff (reset)
        pwr_q == PWR_SOFT_DOWN |-> !main_link_rx_enable && !main_link_data_outputs
            && !ddc_enable && !source_aux_channel && i2c_port_active)
        else $error("paths active during software power-down");

    a_hotplug_mirror: assert property (@(posedge clk) disable iff (reset)
        ##2 source_hotplug_out == $past(sink_hotplug_in, 3))
        else $error("source hotplug does not follow sink hotplug");

    a_cdr_follows: assert property (@(posedge clk) disable iff (reset)
        pwr_q == PWR_NORMAL |-> cdr_enable == sd_s && main_link_data_outputs == sd_s)
        else $error("recovery enable not tied to signal detect");

    a_normal_return: assert property (@(posedge clk) disable iff (reset)
        pe_s && hpd_s && !pd_bit_q |=> pwr_q == PWR_NORMAL && ddc_enable && source_aux_channel)
        else $error("no normal operation with all conditions met");

    a_ratio_cleared: assert property (@(posedge clk) disable iff (reset)
        pd_entry |=> !ratio_q)
        else $error("ratio flag survived power-down entry");

    a_term_decode: assert property (@(posedge clk) disable iff (reset)
        !auto_term_q |-> output_termination_select == term_q)
        else $error("termination select differs from field");

    a_swing_reduce: assert property (@(posedge clk) disable iff (reset)
        swing_reduce_7pct |-> (data_lane_swing & clock_lane_swing) == 3'h7)
        else $error("swing reduction without all ones");

endmodule : retimer_power_control

`default_nettype wire

/* testbench/i2c_host_model.sv */
// i2c host standing in for the video source / controller on the local control port
// assumes the bench resolves the open-drain data line; scl is driven only by this host
`timescale 1ns/10ps
`default_nettype none

module i2c_host_model #(
    parameter logic [6:0] TARGET_ADDR = 7'h2C
) (
    input  wire logic clk,
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // six clocks per quarter keeps scl low and high for twelve, setup six
    task automatic half();
        repeat (6) @(negedge clk);
    endtask : half

    // also serves as repeated start: data released while scl is low
    task automatic start_cond();
        half();
        sda_pull = 1'b0;
        half();
        scl = 1'b1;
        half();
        half();
        sda_pull = 1'b1;
        half();
        half();
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        half();
        sda_pull = 1'b1;
        half();
        scl = 1'b1;
        half();
        half();
        sda_pull = 1'b0;
        half();
        half();
    endtask : stop_cond

    // data only changes while scl is low; the line is sampled mid high phase
    task automatic bit_cycle(input logic b, output logic s);
        half();
        sda_pull = !b;
        half();
        scl = 1'b1;
        half();
        s = sda_line;
        half();
        scl = 1'b0;
    endtask : bit_cycle

    task automatic byte_out(input logic [7:0] v, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(v[i], s);
        bit_cycle(1'b1, s);
        acked = !s;
    endtask : byte_out

    task automatic byte_in(input logic last, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cycle(1'b1, s);
            v[i] = s;
        end
        bit_cycle(last, s);
    endtask : byte_in

    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start_cond();
        byte_out({TARGET_ADDR, 1'b0}, a0);
        byte_out(ptr, a1);
        byte_out(data, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] v);
        logic a;
        start_cond();
        byte_out({TARGET_ADDR, 1'b0}, a);
        byte_out(ptr, a);
        start_cond();
        byte_out({TARGET_ADDR, 1'b1}, a);
        byte_in(1'b1, v);
        stop_cond();
    endtask : read_reg
endmodule : i2c_host_model

`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the retimer power and output control block
// assumes the host model above on the control port; pins driven at falling edges
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import retimer_pkg::*;

    logic clk = 1'b0, reset = 1'b1, power_enable = 1'b0, sink_hotplug_in = 1'b0;
    logic signal_detect = 1'b0, scl, host_pull, dut_do, dut_oe, hp_out, i2c_act;
    logic [2:0] strap_above = 3'h0, strap_below = 3'h0, dswing, cswing;
    logic rx_en, tx_on, cdr_en, ddc_en, aux_en, m2db, red7, ratio, ok;
    logic [1:0] term, slew, emph;
    logic [7:0] rd;
    power_state_t pstate;
    int error_cnt = 0, checks_done = 0;
    wire sda_line = !(host_pull || dut_oe);

    always #2.5 clk = ~clk;

    retimer_power_control DUT (.clk(clk), .reset(reset), .power_enable(power_enable),
        .sink_hotplug_in(sink_hotplug_in), .signal_detect(signal_detect),
        .strap_above(strap_above), .strap_below(strap_below), .local_i2c_clock(scl),
        .local_i2c_data_in(sda_line), .local_i2c_data_out(dut_do),
        .local_i2c_data_oe(dut_oe), .source_hotplug_out(hp_out), .power_state(pstate),
        .i2c_port_active(i2c_act), .main_link_rx_enable(rx_en),
        .main_link_data_outputs(tx_on), .cdr_enable(cdr_en), .ddc_enable(ddc_en),
        .source_aux_channel(aux_en), .output_termination_select(term),
        .edge_rate_select(slew), .emphasis_field(emph), .emphasis_minus2db(m2db),
        .data_lane_swing(dswing), .clock_lane_swing(cswing), .swing_reduce_7pct(red7),
        .high_rate_ratio_flag(ratio));

    i2c_host_model host (.clk(clk), .scl(scl), .sda_pull(host_pull), .sda_line(sda_line));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // pin changes reach power_state in three clocks; twelve also clears i2c start spacing
    task automatic settle();
        repeat (12) @(negedge clk);
    endtask : settle

    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    task automatic t_off();
        sink_hotplug_in = 1'b1;
        settle();
        chk(pstate, PWR_OFF, "off state");
        chk(i2c_act, 1'b0, "i2c off");
        chk(hp_out, 1'b1, "hotplug mirror off");
        chk({dut_do, dut_oe}, 8'h0, "data pin released while off");
        host.write_reg(REG_SLEW_TERM, 8'h88, ok);
        chk(ok, 1'b0, "no ack while off");
    endtask : t_off

    task automatic t_standby();
        strap_above = 3'b001;
        strap_below = 3'b010;
        sink_hotplug_in = 1'b0;
        power_enable = 1'b1;
        settle();
        chk(pstate, PWR_STANDBY, "standby");
        chk({i2c_act, ddc_en, tx_on}, 8'h4, "standby paths");
        chk(hp_out, 1'b0, "hotplug mirror low");
        chk({term, emph, slew}, 8'h35, "strap decode");
        chk(m2db, 1'b1, "strap low emphasis");
    endtask : t_standby

    task automatic t_fields();
        logic [1:0] codes [3] = '{TERM_NONE, TERM_150_300, TERM_75_150};
        foreach (codes[i])
        begin
            host.write_reg(REG_SLEW_TERM, {2'h2, 1'b0, codes[i], 3'h0}, ok);
            chk({ok, slew, term}, {3'h1, 2'h2, codes[i]}, "term field");
        end
        for (int e = 0; e < 2; e++)
        begin
            host.write_reg(REG_SWING_EMPH, {SWING_MINUS7, e[1:0]}, ok);
            chk({m2db, emph}, {5'h0, e[0], e[1:0]}, "emphasis");
            chk({red7, dswing, cswing}, 8'h7F, "swing all ones");
        end
        host.read_reg(REG_SWING_EMPH, rd);
        chk(rd, 8'hFD, "swing readback");
        host.write_reg(REG_SWING_EMPH, 8'h7C, ok);
        chk(red7, 1'b0, "swing not all ones");
        chk({dswing, cswing}, 8'h1F, "lane swing fields");
        host.read_reg(8'h20, rd);
        chk(rd, 8'h00, "unmapped read");
    endtask : t_fields

    task automatic t_normal();
        sink_hotplug_in = 1'b1;
        signal_detect = 1'b0;
        settle();
        chk(pstate, PWR_NORMAL, "normal");
        chk({rx_en, ddc_en, aux_en, i2c_act, hp_out}, 8'h1F, "normal paths");
        chk({tx_on, cdr_en}, 8'h0, "no signal detected");
        signal_detect = 1'b1;
        settle();
        chk({tx_on, cdr_en}, 8'h3, "signal detected");
    endtask : t_normal

    task automatic t_softpd();
        host.write_reg(REG_POWER_DOWN, 8'h08, ok);
        settle();
        chk(pstate, PWR_SOFT_DOWN, "software power-down");
        chk({rx_en, tx_on, cdr_en, ddc_en, aux_en}, 8'h0, "soft down paths");
        chk({i2c_act, hp_out}, 8'h3, "soft down i2c and mirror");
        host.read_reg(REG_POWER_DOWN, rd);
        chk(rd, 8'h28, "power-down readback");
        host.write_reg(REG_POWER_DOWN, 8'h02, ok);
        settle();
        chk({pstate, ratio}, 8'h7, "normal with ratio set");
        sink_hotplug_in = 1'b0;
        settle();
        chk({pstate, ratio, hp_out}, 8'h4, "ratio cleared in standby");
        sink_hotplug_in = 1'b1;
        settle();
        chk(pstate, PWR_NORMAL, "normal again without command");
    endtask : t_softpd

    task automatic t_recycle();
        strap_above = 3'h0;
        strap_below = 3'h0;
        host.write_reg(REG_SWING_EMPH, 8'hFD, ok);
        chk({red7, emph}, 8'h5, "written before enable drop");
        power_enable = 1'b0;
        settle();
        chk({pstate, red7, dswing, emph}, 8'h0, "cleared while off");
        power_enable = 1'b1;
        settle();
        chk({term, emph, slew}, 8'h11, "floating straps auto term");
        host.write_reg(REG_POWER_DOWN, 8'h02, ok);
        chk(term, TERM_75_150, "auto term at high rate");
        host.read_reg(REG_SWING_EMPH, rd);
        chk(rd, 8'h00, "defaults after enable cycle");
        host.write_reg(REG_SLEW_TERM, 8'h98, ok);
        chk({slew, term}, 8'hB, "rewritten config");
    endtask : t_recycle

    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        repeat (16) @(negedge clk);
        reset = 1'b0;
        t_off();
        t_standby();
        t_fields();
        t_normal();
        t_softpd();
        t_recycle();
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
